// ---- rxwb_pkg.sv ----
package rxwb_pkg;

  // ----------------------------------------------------------------
  // Descriptor status word layout
  // ----------------------------------------------------------------
  localparam int OWN_BIT = 31;
  localparam int RING_END_BIT = 30;
  localparam int FIRST_SEG_BIT = 29;
  localparam int LAST_SEG_BIT = 28;
  localparam int MCAST_BIT = 27;
  localparam int UCAST_BIT = 26;
  localparam int BCAST_BIT = 25;
  localparam int BUF_EXH_BIT = 24;
  localparam int FIFO_OVR_BIT = 23;
  localparam int OVERSIZE_BIT = 22;
  localparam int ERR_SUM_BIT = 21;
  localparam int UNDERSIZE_BIT = 20;
  localparam int CRC_ERR_BIT = 19;
  localparam int LEN_MSB = 13;
  localparam int LEN_W = 14;

  // ----------------------------------------------------------------
  // Descriptor ring geometry, frame limits and segment buffer depth
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
  localparam logic [LEN_W-1:0] MAX_LEN = 14'h1000;
  localparam logic [LEN_W-1:0] MIN_LEN = 14'h0040;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RING_BASE = 8'h00;
  localparam logic [7:0] REG_DESC_PTR = 8'h04;
  localparam logic [7:0] REG_STATION_LO = 8'h08;
  localparam logic [7:0] REG_STATION_HI = 8'h0c;
  localparam logic [7:0] REG_CONTROL = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_COUNT = 8'h18;
  localparam logic [31:0] RING_BASE_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Segment report from the buffer manager
  // ----------------------------------------------------------------
  typedef struct packed {
    logic first;
    logic last;
    logic [47:0] dest;
    logic [LEN_W-1:0] length;
    logic crc_err;
    logic align_err;
    logic buf_exh;
    logic fifo_ovr;
  } rxwb_seg_t;

  localparam int SEG_W = $bits(rxwb_seg_t);

  // ----------------------------------------------------------------
  // Descriptor memory port and write-back engine states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } rxwb_mem_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_WAIT = 3'b010,
    ST_CHECK = 3'b011,
    ST_WRITE = 3'b100,
    ST_DONE = 3'b101
  } rxwb_state_t;

endpackage

// ---- rxwb_fifo.sv ----
`timescale 1ns/10ps
module rxwb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } rxwb_fifo_st_t;

  rxwb_fifo_st_t st;
  rxwb_fifo_st_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (st.cnt != (PW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data = mem[st.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wp = st.wp + PW'(1);
    end
    if (pop) begin
      next_st.rp = st.rp + PW'(1);
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + (PW+1)'(1);
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - (PW+1)'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
    if (push) begin
      mem[st.wp] <= in_data;
    end
  end

endmodule

// ---- rxwb_writeback.sv ----
`timescale 1ns/10ps
module rxwb_writeback (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Segment reports from the buffer manager
  input wire logic seg_valid,
  output logic seg_ready,
  input wire rxwb_pkg::rxwb_seg_t seg_data,
  // Descriptor memory port
  output rxwb_pkg::rxwb_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Status outputs
  output logic desc_done,
  output logic host_owned_stall
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    rxwb_pkg::rxwb_state_t state;
    rxwb_pkg::rxwb_mem_req_t req;
    logic [31:0] ring_base;
    logic [31:0] desc_ptr;
    logic [47:0] station;
    logic enable;
    logic ring_end;
    logic [31:0] count;
    logic [31:0] rdata;
    logic done;
    logic stall;
    logic seg_ready;
  } rxwb_st_t;

  rxwb_st_t st;
  rxwb_st_t next_st;

  // ----------------------------------------------------------------
  // Register decoding
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_RING_BASE = 3'b001,
    SEL_DESC_PTR = 3'b010,
    SEL_STATION_LO = 3'b011,
    SEL_STATION_HI = 3'b100,
    SEL_CONTROL = 3'b101,
    SEL_STATUS = 3'b110,
    SEL_COUNT = 3'b111
  } rxwb_sel_t;

  // One decoder shared by the write and the read path
  function automatic rxwb_sel_t reg_decode(input logic [7:0] addr);
    rxwb_sel_t sel;
    if (addr == rxwb_pkg::REG_RING_BASE) begin
      sel = SEL_RING_BASE;
    end else if (addr == rxwb_pkg::REG_DESC_PTR) begin
      sel = SEL_DESC_PTR;
    end else if (addr == rxwb_pkg::REG_STATION_LO) begin
      sel = SEL_STATION_LO;
    end else if (addr == rxwb_pkg::REG_STATION_HI) begin
      sel = SEL_STATION_HI;
    end else if (addr == rxwb_pkg::REG_CONTROL) begin
      sel = SEL_CONTROL;
    end else if (addr == rxwb_pkg::REG_STATUS) begin
      sel = SEL_STATUS;
    end else if (addr == rxwb_pkg::REG_COUNT) begin
      sel = SEL_COUNT;
    end else begin
      sel = SEL_NONE;
    end
    return sel;
  endfunction

  // Unmapped reads give zero
  function automatic logic [31:0] read_mux(
    input rxwb_sel_t sel,
    input rxwb_st_t s
  );
    logic [31:0] v;
    v = '0;
    if (sel == SEL_RING_BASE) begin
      v = s.ring_base;
    end else if (sel == SEL_DESC_PTR) begin
      v = s.desc_ptr;
    end else if (sel == SEL_STATION_LO) begin
      v = s.station[31:0];
    end else if (sel == SEL_STATION_HI) begin
      v = {16'h0000, s.station[47:32]};
    end else if (sel == SEL_CONTROL) begin
      v = {31'h0000_0000, s.enable};
    end else if (sel == SEL_STATUS) begin
      v = {28'h000_0000, s.stall, s.state};
    end else if (sel == SEL_COUNT) begin
      v = s.count;
    end
    return v;
  endfunction

  rxwb_sel_t reg_sel;

  assign reg_sel = reg_decode(reg_addr);

  logic fifo_valid;
  logic fifo_take;
  rxwb_pkg::rxwb_seg_t seg;
  logic [rxwb_pkg::SEG_W-1:0] seg_bits;
  logic fifo_in_ready;

  assign seg = rxwb_pkg::rxwb_seg_t'(seg_bits);

  // ----------------------------------------------------------------
  // Segment buffer
  // ----------------------------------------------------------------
  rxwb_fifo #(
    .WIDTH(rxwb_pkg::SEG_W),
    .DEPTH(rxwb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(seg_valid),
    .in_ready(fifo_in_ready),
    .in_data(seg_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(seg_bits)
  );

  // ----------------------------------------------------------------
  // Status word builder
  // ----------------------------------------------------------------
  function automatic logic [31:0] build_status(
    input rxwb_pkg::rxwb_seg_t s,
    input logic [47:0] station,
    input logic ring_end
  );
    logic [31:0] w;
    logic bcast;
    logic mcast;
    logic over;
    logic under;
    w = '0;
    bcast = (s.dest == {48{1'b1}});
    mcast = s.dest[0] && !bcast;
    over = s.length > rxwb_pkg::MAX_LEN;
    under = s.length < rxwb_pkg::MIN_LEN;
    w[rxwb_pkg::OWN_BIT] = 1'b0;
    w[rxwb_pkg::RING_END_BIT] = ring_end;
    w[rxwb_pkg::FIRST_SEG_BIT] = s.first;
    w[rxwb_pkg::LAST_SEG_BIT] = s.last;
    w[rxwb_pkg::MCAST_BIT] = mcast;
    w[rxwb_pkg::UCAST_BIT] = (s.dest == station);
    w[rxwb_pkg::BCAST_BIT] = bcast;
    w[rxwb_pkg::BUF_EXH_BIT] = s.buf_exh;
    w[rxwb_pkg::FIFO_OVR_BIT] = s.fifo_ovr;
    if (s.last) begin
      w[rxwb_pkg::OVERSIZE_BIT] = over;
      w[rxwb_pkg::UNDERSIZE_BIT] = under;
      w[rxwb_pkg::CRC_ERR_BIT] = s.crc_err;
      w[rxwb_pkg::ERR_SUM_BIT] = s.crc_err || under || over ||
        s.align_err;
      w[rxwb_pkg::LEN_MSB:0] = s.length;
    end
    return w;
  endfunction

  assign fifo_take = (st.state == rxwb_pkg::ST_DONE);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.rdata = '0;
    next_st.seg_ready = fifo_in_ready;
    if (reg_wr) begin
      if (reg_sel == SEL_RING_BASE) begin
        next_st.ring_base = reg_wdata;
        next_st.desc_ptr = reg_wdata;
      end else if (reg_sel == SEL_STATION_LO) begin
        next_st.station[31:0] = reg_wdata;
      end else if (reg_sel == SEL_STATION_HI) begin
        next_st.station[47:32] = reg_wdata[15:0];
      end else if (reg_sel == SEL_CONTROL) begin
        next_st.enable = reg_wdata[0];
      end
    end
    if (reg_rd) begin
      next_st.rdata = read_mux(reg_sel, st);
    end
    case (st.state)
      rxwb_pkg::ST_IDLE: begin
        if (st.enable && fifo_valid) begin
          next_st.state = rxwb_pkg::ST_FETCH;
        end
      end
      rxwb_pkg::ST_FETCH: begin
        next_st.req.rd = 1'b1;
        next_st.req.wr = 1'b0;
        next_st.req.addr = st.desc_ptr;
        next_st.state = rxwb_pkg::ST_WAIT;
      end
      rxwb_pkg::ST_WAIT: begin
        if (mem_ack) begin
          next_st.req.rd = 1'b0;
          next_st.state = rxwb_pkg::ST_CHECK;
          if (!mem_rdata[rxwb_pkg::OWN_BIT]) begin
            // Host still holds it: wait and poll again
            next_st.stall = 1'b1;
            next_st.state = rxwb_pkg::ST_IDLE;
          end else begin
            next_st.stall = 1'b0;
            next_st.ring_end = mem_rdata[rxwb_pkg::RING_END_BIT];
          end
        end
      end
      rxwb_pkg::ST_CHECK: begin
        // Whole word in one write, so no partial status is visible
        next_st.req.wr = 1'b1;
        next_st.req.addr = st.desc_ptr;
        next_st.req.wdata = build_status(seg, st.station, st.ring_end);
        next_st.state = rxwb_pkg::ST_WRITE;
      end
      rxwb_pkg::ST_WRITE: begin
        if (mem_ack) begin
          next_st.req.wr = 1'b0;
          next_st.state = rxwb_pkg::ST_DONE;
        end
      end
      rxwb_pkg::ST_DONE: begin
        if (st.ring_end) begin
          next_st.desc_ptr = st.ring_base;
        end else begin
          next_st.desc_ptr = st.desc_ptr + rxwb_pkg::DESC_STRIDE;
        end
        next_st.count = st.count + 32'h0000_0001;
        next_st.done = 1'b1;
        next_st.state = rxwb_pkg::ST_IDLE;
      end
      default: begin
        next_st.state = rxwb_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
      st.ring_base <= rxwb_pkg::RING_BASE_RST;
      st.desc_ptr <= rxwb_pkg::RING_BASE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign mem_req = st.req;
  assign reg_rdata = st.rdata;
  assign desc_done = st.done;
  assign host_owned_stall = st.stall;
  assign seg_ready = st.seg_ready;

endmodule

// ---- rxwb_writeback_asserts.sv ----
`timescale 1ns/10ps
module rxwb_writeback_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Segment side
  input wire logic seg_valid,
  input wire logic seg_ready,
  input wire rxwb_pkg::rxwb_seg_t seg_data,
  // Memory side
  input wire rxwb_pkg::rxwb_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Register side
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Status
  input wire logic desc_done,
  input wire logic host_owned_stall
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [31:0] w;
  logic wl;
  assign w = mem_req.wdata;
  assign wl = mem_req.wr && w[28];
  own_clear_a: assert property (mem_req.wr |-> !w[31])
    else $error("ownership left set");
  mc_bc_excl_a: assert property (mem_req.wr |-> !(w[27] && w[25]))
    else $error("broadcast and multicast together");
  wr_steady_a: assert property (
    mem_req.wr && !mem_ack |=> $stable(mem_req))
    else $error("write changed before ack");
  done_after_wr_a: assert property (
    mem_req.wr && mem_ack |-> ##[1:3] desc_done)
    else $error("no hand back after write");
  seg_len_zero_a: assert property (
    mem_req.wr && !w[28] |-> w[13:0] == 14'h0000 && !w[21])
    else $error("length in middle segment");
  err_summary_a: assert property (
    wl && (w[22] || w[20] || w[19]) |-> w[21])
    else $error("error summary missing");
  oversize_a: assert property (
    wl |-> w[22] == (w[13:0] > rxwb_pkg::MAX_LEN))
    else $error("oversize flag wrong");
  undersize_a: assert property (
    wl |-> w[20] == (w[13:0] < rxwb_pkg::MIN_LEN))
    else $error("undersize flag wrong");
endmodule

bind rxwb_writeback rxwb_writeback_chk u_rxwb_writeback_chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .seg_valid(seg_valid),
  .seg_ready(seg_ready),
  .seg_data(seg_data),
  .mem_req(mem_req),
  .mem_ack(mem_ack),
  .mem_rdata(mem_rdata),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .desc_done(desc_done),
  .host_owned_stall(host_owned_stall)
);

// ---- rxwb_mem_model.sv ----
`timescale 1ns/10ps
module rxwb_mem_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Descriptor port
  input wire rxwb_pkg::rxwb_mem_req_t mem_req,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Answer delay in cycles
  input wire logic [3:0] delay
);
  logic [31:0] words [0:7];
  logic [3:0] cnt;
  // Word 0 of each descriptor; a write replaces the word whatever its ownership bit
  always @(posedge sys_clk) begin
    if (rst) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 32'h5a5a_a5a5;
    end else if ((mem_req.rd || mem_req.wr) && !mem_ack) begin
      if (cnt == delay) begin
        mem_ack <= 1'b1;
        cnt <= 4'h0;
        mem_rdata <= words[mem_req.addr[6:4]];
        if (mem_req.wr) begin
          words[mem_req.addr[6:4]] <= mem_req.wdata;
        end
      end else begin
        cnt <= cnt + 4'h1;
      end
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// ---- tb_rxwb_writeback.sv ----
`timescale 1ns/10ps
module tb_rxwb_writeback;
  localparam logic [31:0] BASE = 32'h0000_1000;
  localparam logic [47:0] STN = 48'h0a0b_0c0d_0e10;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic seg_valid = 1'b0;
  logic seg_ready;
  rxwb_pkg::rxwb_seg_t seg_data = '0;
  rxwb_pkg::rxwb_mem_req_t mem_req;
  logic mem_ack;
  logic [31:0] mem_rdata;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic desc_done;
  logic host_owned_stall;
  logic [3:0] delay = 4'h3;
  int mismatches = 0;
  int total_checks = 0;
  rxwb_pkg::rxwb_seg_t segs [0:4];
  always #12.5 sys_clk = ~sys_clk;
  rxwb_writeback u_rxwb_writeback (.sys_clk(sys_clk), .rst(rst),
    .seg_valid(seg_valid), .seg_ready(seg_ready), .seg_data(seg_data),
    .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .desc_done(desc_done),
    .host_owned_stall(host_owned_stall));
  rxwb_mem_model u_rxwb_mem_model (.sys_clk(sys_clk), .rst(rst),
    .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .delay(delay));
  function automatic logic [31:0] status(rxwb_pkg::rxwb_seg_t s, logic re);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[30] = re;
    v[29] = s.first;
    v[28] = s.last;
    v[25] = &s.dest;
    v[27] = s.dest[0] && !v[25];
    v[26] = (s.dest == STN);
    v[24] = s.buf_exh;
    v[23] = s.fifo_ovr;
    if (s.last) begin
      v[22] = s.length > 14'h1000;
      v[20] = s.length < 14'h0040;
      v[19] = s.crc_err;
      v[21] = v[22] | v[20] | v[19] | s.align_err;
      v[13:0] = s.length;
    end
    return v;
  endfunction
  task automatic final_report();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_write(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(logic [7:0] a, logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    check("reg_rdata", reg_rdata, exp);
  endtask
  task automatic push(rxwb_pkg::rxwb_seg_t s);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (seg_ready !== 1'b1 && n < 100);
    @(posedge sys_clk);
    seg_valid <= 1'b1;
    seg_data <= s;
    @(posedge sys_clk);
    seg_valid <= 1'b0;
    seg_data <= ~s;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (desc_done !== 1'b1 && n < 200);
    check("desc_done", {31'h0, desc_done}, 32'h0000_0001);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    final_report();
  end
  initial begin
    segs[0] = '{1'b1, 1'b0, 48'h0000_0000_0002, 14'h0100, 1'b0, 1'b0, 1'b0, 1'b0};
    segs[1] = '{1'b0, 1'b1, STN, 14'h1001, 1'b1, 1'b0, 1'b0, 1'b0};
    segs[2] = '{1'b1, 1'b1, 48'hffff_ffff_ffff, 14'h003f, 1'b0, 1'b0, 1'b1, 1'b0};
    segs[3] = '{1'b1, 1'b1, 48'h1234_5678_9ab1, 14'h1000, 1'b0, 1'b1, 1'b0, 1'b1};
    segs[4] = '{1'b1, 1'b1, 48'h0000_0000_0002, 14'h0040, 1'b0, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 8; i++) begin
      u_rxwb_mem_model.words[i] = (i == 7) ? 32'hc000_0000 : 32'h8000_0000;
    end
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    reg_write(rxwb_pkg::REG_RING_BASE, BASE);
    reg_write(rxwb_pkg::REG_STATION_LO, STN[31:0]);
    reg_write(rxwb_pkg::REG_STATION_HI, {16'h0000, STN[47:32]});
    reg_read(rxwb_pkg::REG_STATION_HI, {16'h0000, STN[47:32]});
    reg_read(rxwb_pkg::REG_STATION_LO, STN[31:0]);
    reg_read(rxwb_pkg::REG_RING_BASE, BASE);
    reg_read(8'h1c, 32'h0000_0000);
    reg_write(rxwb_pkg::REG_DESC_PTR, 32'h0000_0040);
    reg_read(rxwb_pkg::REG_DESC_PTR, BASE);
    // Fill the queue while the engine is off, then drain with a slow memory
    for (int i = 0; i < 8; i++) push(segs[i % 4]);
    @(negedge sys_clk);
    check("seg_ready", {31'h0, seg_ready}, 32'h0000_0000);
    reg_write(rxwb_pkg::REG_CONTROL, 32'h0000_0001);
    for (int i = 0; i < 8; i++) wait_done();
    for (int i = 0; i < 8; i++) begin
      check("desc", u_rxwb_mem_model.words[i], status(segs[i % 4], i == 7));
    end
    reg_read(rxwb_pkg::REG_DESC_PTR, BASE);
    reg_read(rxwb_pkg::REG_COUNT, 32'h0000_0008);
    check("seg_ready", {31'h0, seg_ready}, 32'h0000_0001);
    // Wrapped onto a host-held descriptor: it must wait for the host
    delay <= 4'h0;
    push(segs[4]);
    repeat (30) @(posedge sys_clk);
    @(negedge sys_clk);
    check("stall", {31'h0, host_owned_stall}, 32'h0000_0001);
    check("desc0", u_rxwb_mem_model.words[0], status(segs[0], 1'b0));
    u_rxwb_mem_model.words[0] = 32'h8000_0000;
    wait_done();
    check("stall", {31'h0, host_owned_stall}, 32'h0000_0000);
    check("desc0", u_rxwb_mem_model.words[0], status(segs[4], 1'b0));
    reg_read(rxwb_pkg::REG_DESC_PTR, BASE + 32'h0000_0010);
    reg_read(rxwb_pkg::REG_STATUS, 32'h0000_0000);
    reg_read(rxwb_pkg::REG_CONTROL, 32'h0000_0001);
    final_report();
  end
endmodule
